// file: logic/mdc_pkg.sv
// Shared constants for the DMA channel control core.
// Assumes a 32-bit memory bus with word-aligned accesses.
package mdc_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    // The control table base is aligned to this many bytes.
    localparam int unsigned TABLE_ALIGN_BYTES = 1024;
    localparam int unsigned ALIGN_BITS = $clog2(TABLE_ALIGN_BYTES);
    localparam logic [ADDR_W-1:0] ALIGN_MASK = ~(ADDR_W'(TABLE_ALIGN_BYTES) - 32'h0000_0001);
    // Each control structure is four words; the alternate half begins at this offset.
    localparam int unsigned STRUCT_SHIFT = 4;
    localparam logic [ADDR_W-1:0] ALT_HALF_OFS = 32'h0000_0200;
    localparam logic [ADDR_W-1:0] SRC_END_OFS = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] DST_END_OFS = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] CTL_OFS = 32'h0000_0008;
    // Control word layout.
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned CNT_LSB = 4;
    localparam int unsigned CNT_W = 10;
    localparam logic [MODE_W-1:0] MODE_STOPPED = 3'h0;
    // Items are words; an item index becomes a byte offset by this shift.
    localparam int unsigned ITEM_SHIFT = 2;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
endpackage : mdc_pkg

// file: logic/mdc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes DEPTH is a power of two and a single clock.
`timescale 1ns/100ps
`default_nettype none
module mdc_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = PW + 1;
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic push, pop;

    always_comb begin
        in_ready = (count != CW'(DEPTH));
        out_valid = (count != '0);
        out_data = store[rd_ptr];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = CW'(count + CW'(push) - CW'(pop));
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage carries no reset; only the pointers decide what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end
endmodule // mdc_fifo
`default_nettype wire

// file: logic/mdc_sticky.sv
// Sticky flag that hardware sets and software clears.
// Assumes set and clear are one-cycle pulses on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mdc_sticky (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic next_q;

    // A set in the clearing cycle wins, so no error is lost.
    always_comb begin
        next_q = set | (q & ~clr);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end
endmodule // mdc_sticky
`default_nettype wire

// file: logic/mdc_core.sv
// Global control and transfer engine of the micro DMA controller.
// Assumes a single-outstanding memory port where MEM_ACK answers MEM_REQ.
//
// Notes on behaviour
// - Table base sits on a 1024-byte boundary; low ten bits forced to zero.
// - Channel control is fetched from a memory table at a readable base pointer.
// - No new item starts while the global enable is clear; an item already begun runs to its write-back.
// - After disable the engine stays idle until enabled again.
// - A transfer error raises a pending error held until software clears it.
// - Error status reads non-zero while pending, zero after clearing.
// - Alternate structures live in the second half; its base is readable.
// - On completion the structure mode is written back as stopped.
// - A channel enable clears itself when its transfer completes.
// - Item count is decremented in memory as items move; zero at end.
`timescale 1ns/100ps
`default_nettype none
module mdc_core
    import mdc_pkg::*;
#(
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned FIFO_DEPTH = 4
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic GLOBAL_EN,
    input wire logic BASE_WR,
    input wire logic [mdc_pkg::ADDR_W-1:0] BASE_WDATA,
    output logic [mdc_pkg::ADDR_W-1:0] BASE_PTR,
    output logic [mdc_pkg::ADDR_W-1:0] ALT_BASE_PTR,
    output logic BASE_VALID,
    input wire logic [NUM_CH-1:0] CH_EN_SET,
    input wire logic [NUM_CH-1:0] ALTERNATE_STRUCTURE_SELECT,
    input wire logic [NUM_CH-1:0] CH_REQ,
    output logic [NUM_CH-1:0] CH_ENABLED,
    output logic [NUM_CH-1:0] CH_DONE,
    input wire logic ERR_CLEAR,
    output logic ERROR_PENDING,
    output logic ACTIVE,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [mdc_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic [mdc_pkg::DATA_W-1:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic MEM_ERR,
    input wire logic [mdc_pkg::DATA_W-1:0] MEM_RDATA
);
    import mdc_pkg::*;

    localparam int unsigned CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SRC,
        ST_DST,
        ST_CTL,
        ST_RD,
        ST_WR,
        ST_WB
    } mdc_state_e;

    mdc_state_e state, next_state;
    logic [CH_W-1:0] ch, next_ch;
    logic [ADDR_W-1:0] base, next_base, alt_base, next_alt_base;
    logic base_valid, next_base_valid;
    logic [ADDR_W-1:0] src_end, next_src_end, dst_end, next_dst_end;
    logic [DATA_W-1:0] ctl, next_ctl;
    logic [NUM_CH-1:0] ch_en, next_ch_en, done, next_done;
    logic mem_req, next_mem_req, mem_we, next_mem_we;
    logic [ADDR_W-1:0] mem_addr, next_mem_addr;
    logic [DATA_W-1:0] mem_wdata, next_mem_wdata;
    logic active, next_active;
    logic err_set;
    logic err_q;
    logic fifo_push, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
    logic [DATA_W-1:0] fifo_out;
    logic acked;
    logic pick_hit;
    logic [CH_W-1:0] pick;
    logic [CNT_W-1:0] cnt, cnt_dec;
    logic [ADDR_W-1:0] item_ofs, struct_addr;

    // Lowest-numbered enabled channel with a pending request wins.
    always_comb begin
        pick_hit = 1'b0;
        pick = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (ch_en[i] && CH_REQ[i]) begin
                pick_hit = 1'b1;
                pick = CH_W'(i);
            end
        end
    end

    always_comb begin
        cnt = ctl[CNT_LSB +: CNT_W];
        cnt_dec = CNT_W'(cnt - CNT_ONE);
        // End-pointer addressing: the remaining count locates the next item.
        item_ofs = ADDR_W'({cnt_dec, {ITEM_SHIFT{1'b0}}});
        struct_addr = ADDR_W'(ADDR_W'(ch) << STRUCT_SHIFT);
    end

    always_comb begin
        next_state = state;
        next_ch = ch;
        next_base = base;
        next_alt_base = alt_base;
        next_base_valid = base_valid;
        next_src_end = src_end;
        next_dst_end = dst_end;
        next_ctl = ctl;
        // Software's set wins over the completion clear of the same cycle.
        next_ch_en = ch_en;
        next_done = '0;
        next_mem_req = mem_req;
        next_mem_we = mem_we;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        err_set = 1'b0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_flush = 1'b0;
        acked = mem_req & MEM_ACK;

        if (BASE_WR) begin
            next_base = BASE_WDATA & ALIGN_MASK;
            next_alt_base = (BASE_WDATA & ALIGN_MASK) + ALT_HALF_OFS;
            next_base_valid = 1'b1;
        end

        case (state)
            ST_IDLE: begin
                // A new item starts only while enabled and after the base is set.
                if (GLOBAL_EN && base_valid && pick_hit) begin
                    next_ch = pick;
                    next_mem_req = 1'b1;
                    next_mem_we = 1'b0;
                    next_mem_addr = (ALTERNATE_STRUCTURE_SELECT[pick] ? alt_base : base)
                        + ADDR_W'(ADDR_W'(pick) << STRUCT_SHIFT) + SRC_END_OFS;
                    next_state = ST_SRC;
                end
            end
            ST_SRC: begin
                if (acked) begin
                    next_src_end = MEM_RDATA;
                    next_mem_addr = (ALTERNATE_STRUCTURE_SELECT[ch] ? alt_base : base)
                        + struct_addr + DST_END_OFS;
                    next_state = ST_DST;
                end
            end
            ST_DST: begin
                if (acked) begin
                    next_dst_end = MEM_RDATA;
                    next_mem_addr = (ALTERNATE_STRUCTURE_SELECT[ch] ? alt_base : base)
                        + struct_addr + CTL_OFS;
                    next_state = ST_CTL;
                end
            end
            ST_CTL: begin
                if (acked) begin
                    next_ctl = MEM_RDATA;
                    next_mem_req = 1'b0;
                    if (MEM_RDATA[MODE_LSB +: MODE_W] == MODE_STOPPED ||
                        MEM_RDATA[CNT_LSB +: CNT_W] == CNT_ZERO) begin
                        // A stopped structure has nothing to move; the channel is released.
                        next_ch_en[ch] = 1'b0;
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_RD;
                    end
                end
            end
            ST_RD: begin
                if (!mem_req) begin
                    if (fifo_in_ready) begin
                        next_mem_req = 1'b1;
                        next_mem_we = 1'b0;
                        next_mem_addr = src_end - item_ofs;
                    end
                end else if (acked) begin
                    fifo_push = ~MEM_ERR;
                    next_mem_req = 1'b0;
                    next_state = ST_WR;
                end
            end
            ST_WR: begin
                if (!mem_req) begin
                    if (fifo_out_valid) begin
                        fifo_pop = 1'b1;
                        next_mem_req = 1'b1;
                        next_mem_we = 1'b1;
                        next_mem_addr = dst_end - item_ofs;
                        next_mem_wdata = fifo_out;
                    end
                end else if (acked) begin
                    next_ctl[CNT_LSB +: CNT_W] = cnt_dec;
                    if (cnt_dec == CNT_ZERO) begin
                        next_ctl[MODE_LSB +: MODE_W] = MODE_STOPPED;
                    end
                    next_mem_addr = (ALTERNATE_STRUCTURE_SELECT[ch] ? alt_base : base)
                        + struct_addr + CTL_OFS;
                    next_mem_wdata = ctl;
                    next_mem_wdata[CNT_LSB +: CNT_W] = cnt_dec;
                    if (cnt_dec == CNT_ZERO) begin
                        next_mem_wdata[MODE_LSB +: MODE_W] = MODE_STOPPED;
                    end
                    next_state = ST_WB;
                end
            end
            ST_WB: begin
                if (acked) begin
                    next_mem_req = 1'b0;
                    next_mem_we = 1'b0;
                    if (ctl[CNT_LSB +: CNT_W] == CNT_ZERO) begin
                        next_ch_en[ch] = 1'b0;
                        next_done[ch] = 1'b1;
                    end
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_mem_req = 1'b0;
            end
        endcase

        // An error answer on any access, table fetch included, halts the channel.
        if (acked && MEM_ERR) begin
            err_set = 1'b1;
            next_ch_en[ch] = 1'b0;
            next_mem_req = 1'b0;
            next_mem_we = 1'b0;
            fifo_flush = 1'b1;
            next_state = ST_IDLE;
        end

        next_ch_en = next_ch_en | CH_EN_SET;
        next_active = (next_state != ST_IDLE);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            ch <= '0;
            base <= '0;
            alt_base <= '0;
            base_valid <= 1'b0;
            src_end <= '0;
            dst_end <= '0;
            ctl <= '0;
            ch_en <= '0;
            done <= '0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            active <= 1'b0;
        end else begin
            state <= next_state;
            ch <= next_ch;
            base <= next_base;
            alt_base <= next_alt_base;
            base_valid <= next_base_valid;
            src_end <= next_src_end;
            dst_end <= next_dst_end;
            ctl <= next_ctl;
            ch_en <= next_ch_en;
            done <= next_done;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            active <= next_active;
        end
    end

    // Read data passes through the buffer; a write waits until a word is there.
    mdc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst(RST),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(MEM_RDATA),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    mdc_sticky u_err (
        .clk(CLK),
        .rst(RST),
        .set(err_set),
        .clr(ERR_CLEAR),
        .q(err_q)
    );

    assign BASE_PTR = base;
    assign ALT_BASE_PTR = alt_base;
    assign BASE_VALID = base_valid;
    assign CH_ENABLED = ch_en;
    assign CH_DONE = done;
    assign ERROR_PENDING = err_q;
    assign ACTIVE = active;
    assign MEM_REQ = mem_req;
    assign MEM_WE = mem_we;
    assign MEM_ADDR = mem_addr;
    assign MEM_WDATA = mem_wdata;
endmodule // mdc_core
`default_nettype wire

// file: verif/mdc_mem_model.sv
// Behavioural system memory on the far side of the core's memory port.
// Assumes one outstanding request held until acknowledged; the bench sets latency and an error address.
`timescale 1ns/100ps
`default_nettype none
module mdc_mem_model
    import mdc_pkg::*;
(
    input wire logic clk,
    input wire logic req,
    input wire logic we,
    input wire logic [mdc_pkg::ADDR_W-1:0] addr,
    input wire logic [mdc_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] lat,
    input wire logic err_on,
    input wire logic [mdc_pkg::ADDR_W-1:0] err_addr,
    output logic ack,
    output logic err,
    output logic [mdc_pkg::DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    int cnt = 0;
    logic done;
    initial begin
        ack = 1'b0;
        err = 1'b0;
        rdata = 32'h5A5A_5A5A;
    end
    // The ack always drops for a cycle after a completed access, so this memory is never faster than the port.
    always @(posedge clk) begin
        done = ack && req;
        #1;
        if (done || !req) begin
            ack = 1'b0;
            err = 1'b0;
            cnt = 0;
            // Read data is not held once released, so a late sample cannot pass by luck.
            rdata = ~rdata;
        end else if (cnt >= int'(lat)) begin
            ack = 1'b1;
            err = err_on && (addr == err_addr);
            if (we && !err) mem[addr] = wdata;
            else if (!we) rdata = err ? ~rdata : mem[addr];
        end else begin
            cnt++;
        end
    end
endmodule // mdc_mem_model
`default_nettype wire

// file: verif/mdc_core_sva.sv
// Concurrent checks on the ports of the DMA channel control core.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mdc_core_sva
    import mdc_pkg::*;
#(
    parameter int unsigned NUM_CH = 4
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic GLOBAL_EN,
    input wire logic BASE_WR,
    input wire logic [mdc_pkg::ADDR_W-1:0] BASE_WDATA,
    input wire logic [mdc_pkg::ADDR_W-1:0] BASE_PTR,
    input wire logic [mdc_pkg::ADDR_W-1:0] ALT_BASE_PTR,
    input wire logic BASE_VALID,
    input wire logic [NUM_CH-1:0] CH_ENABLED,
    input wire logic [NUM_CH-1:0] CH_DONE,
    input wire logic ERR_CLEAR,
    input wire logic ERROR_PENDING,
    input wire logic ACTIVE,
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [mdc_pkg::ADDR_W-1:0] MEM_ADDR,
    input wire logic [mdc_pkg::DATA_W-1:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic MEM_ERR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic bus_err;
    assign bus_err = MEM_REQ && MEM_ACK && MEM_ERR;
    property p_base_write;
        BASE_WR |=> BASE_VALID && BASE_PTR == ($past(BASE_WDATA) & ALIGN_MASK);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base pointer write wrong");
    property p_valid_stays;
        BASE_VALID |=> BASE_VALID;
    endproperty
    a_valid_stays: assert property (p_valid_stays) else $error("base valid dropped");
    property p_alt_half;
        BASE_VALID |-> ALT_BASE_PTR == BASE_PTR + ALT_HALF_OFS;
    endproperty
    a_alt_half: assert property (p_alt_half) else $error("alternate base wrong");
    property p_req_hold;
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");
    property p_no_req_idle;
        MEM_REQ |-> ACTIVE;
    endproperty
    a_no_req_idle: assert property (p_no_req_idle) else $error("memory request while idle");
    property p_stay_idle;
        !GLOBAL_EN && !ACTIVE |=> !ACTIVE;
    endproperty
    a_stay_idle: assert property (p_stay_idle) else $error("engine started while disabled");
    property p_err_stops;
        bus_err |=> ERROR_PENDING && !MEM_REQ;
    endproperty
    a_err_stops: assert property (p_err_stops) else $error("bus error not flagged or engine ran on");
    property p_err_cause;
        $rose(ERROR_PENDING) |-> $past(bus_err);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error raised without bus error");
    property p_err_hold;
        ERROR_PENDING && !ERR_CLEAR |=> ERROR_PENDING;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped without clear");
    property p_err_clear;
        ERR_CLEAR && !bus_err |=> !ERROR_PENDING;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error not cleared");
    property p_done_pulse;
        CH_DONE != '0 |=> CH_DONE == '0 [*2];
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_done_clears;
        CH_DONE != '0 |-> (CH_DONE & CH_ENABLED) == '0;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("enable still set at done");
endmodule // mdc_core_sva
bind mdc_core mdc_core_sva #(.NUM_CH(NUM_CH)) u_sva (.CLK, .RST, .GLOBAL_EN, .BASE_WR, .BASE_WDATA, .BASE_PTR,
    .ALT_BASE_PTR, .BASE_VALID, .CH_ENABLED, .CH_DONE, .ERR_CLEAR, .ERROR_PENDING, .ACTIVE, .MEM_REQ, .MEM_WE,
    .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_ERR);
`default_nettype wire

// file: verif/mdc_core_bench.sv
// Self-checking bench for the DMA channel control core with a behavioural memory.
// Assumes the memory model answers every request; the bench plays software and the peripherals.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module mdc_core_bench;
    import mdc_pkg::*;
    typedef struct {logic [31:0] wd; logic [31:0] base; int ch; logic alt; logic [CNT_W-1:0] cnt; logic [3:0] lat;} mdc_row_s;
    mdc_row_s rows [4] = '{'{32'h0000_13FF, 32'h0000_1000, 0, 1'b0, 10'h001, 4'h0},
        '{32'h2000_0000, 32'h2000_0000, 3, 1'b1, 10'h003, 4'h2}, '{32'h0000_4A10, 32'h0000_4800, 1, 1'b1, 10'h002, 4'h0},
        '{32'h8000_07FF, 32'h8000_0400, 2, 1'b0, 10'h004, 4'h3}};
    logic CLK = 1'b0, RST = 1'b1, GLOBAL_EN = 1'b0, BASE_WR = 1'b0, ERR_CLEAR = 1'b0, err_on = 1'b0;
    logic [31:0] BASE_WDATA = '0, err_addr = '0, BASE_PTR, ALT_BASE_PTR, MEM_ADDR, MEM_WDATA, MEM_RDATA, sa, se, de, ctl;
    logic [3:0] CH_EN_SET = '0, ALTERNATE_STRUCTURE_SELECT = '0, CH_REQ = '0, lat = '0, CH_ENABLED, CH_DONE;
    logic BASE_VALID, ERROR_PENDING, ACTIVE, MEM_REQ, MEM_WE, MEM_ACK, MEM_ERR;
    int n_fail = 0, num_checks = 0;
    always #2 CLK = ~CLK;
    mdc_core #(.NUM_CH(4), .FIFO_DEPTH(4)) dut (.CLK, .RST, .GLOBAL_EN, .BASE_WR, .BASE_WDATA, .BASE_PTR,
        .ALT_BASE_PTR, .BASE_VALID, .CH_EN_SET, .ALTERNATE_STRUCTURE_SELECT, .CH_REQ, .CH_ENABLED, .CH_DONE,
        .ERR_CLEAR, .ERROR_PENDING, .ACTIVE, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_ERR, .MEM_RDATA);
    mdc_mem_model mem_i (.clk(CLK), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA), .lat(lat),
        .err_on(err_on), .err_addr(err_addr), .ack(MEM_ACK), .err(MEM_ERR), .rdata(MEM_RDATA));
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask
    // Builds one control structure, fills the source, then enables and requests the channel.
    task automatic start(input logic [31:0] base, input int ch, input logic alt, input logic [CNT_W-1:0] n);
        sa = base + (alt ? ALT_HALF_OFS : 32'h0000_0000) + 32'(ch << STRUCT_SHIFT);
        se = 32'h0001_00FC + 32'(ch << 8);
        de = se + 32'h0001_0000;
        ctl = (32'(n) << CNT_LSB) | 32'h0000_0001;
        mem_i.mem[sa + SRC_END_OFS] = se;
        mem_i.mem[sa + DST_END_OFS] = de;
        mem_i.mem[sa + CTL_OFS] = ctl;
        for (int i = 0; i < int'(n); i++) mem_i.mem[se - 32'(i * 4)] = 32'hA5A5_0000 ^ (se - 32'(i * 4));
        for (int i = 0; i < int'(n); i++) mem_i.mem[de - 32'(i * 4)] = 32'h0000_0000;
        ALTERNATE_STRUCTURE_SELECT[ch] = alt;
        CH_EN_SET[ch] = 1'b1;
        CH_REQ[ch] = 1'b1;
        step(1);
        CH_EN_SET = '0;
    endtask
    task automatic finish_ch(input int ch, input logic [CNT_W-1:0] n);
        int k;
        for (k = 0; k < 800 && CH_DONE[ch] !== 1'b1; k++) step(1);
        `CHK("done", 1'b1, CH_DONE[ch])
        CH_REQ[ch] = 1'b0;
        step(1);
        `CHK("enable", 1'b0, CH_ENABLED[ch])
        `CHK("control", 32'h0000_0000, mem_i.mem[sa + CTL_OFS])
        for (int i = 0; i < int'(n); i++) `CHK("item", 32'hA5A5_0000 ^ (se - 32'(i * 4)), mem_i.mem[de - 32'(i * 4)])
    endtask
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
    initial begin
        int k;
        step(2);
        RST = 1'b0;
        step(1);
        `CHK("valid", 1'b0, BASE_VALID)
        `CHK("error", 1'b0, ERROR_PENDING)
        GLOBAL_EN = 1'b1;
        foreach (rows[r]) begin
            lat = rows[r].lat;
            BASE_WR = 1'b1;
            // Base goes in before any channel is touched.
            BASE_WDATA = rows[r].wd;
            step(1);
            BASE_WR = 1'b0;
            `CHK("base", rows[r].base, BASE_PTR)
            `CHK("alt base", rows[r].base + ALT_HALF_OFS, ALT_BASE_PTR)
            start(rows[r].base, rows[r].ch, rows[r].alt, rows[r].cnt);
            finish_ch(rows[r].ch, rows[r].cnt);
        end
        GLOBAL_EN = 1'b0;
        start(32'h8000_0400, 2, 1'b0, 10'h003);
        step(20);
        `CHK("idle", 1'b0, ACTIVE)
        `CHK("held", 1'b1, CH_ENABLED[2])
        GLOBAL_EN = 1'b1;
        for (k = 0; k < 200 && (MEM_REQ & MEM_WE & MEM_ACK) !== 1'b1; k++) step(1);
        GLOBAL_EN = 1'b0;
        step(30);
        `CHK("stopped", 1'b0, ACTIVE)
        `CHK("count", ctl - 32'h0000_0010, mem_i.mem[sa + CTL_OFS])
        GLOBAL_EN = 1'b1;
        finish_ch(2, 10'h003);
        start(32'h8000_0400, 1, 1'b0, 10'h002);
        err_addr = sa + CTL_OFS;
        err_on = 1'b1;
        for (k = 0; k < 200 && ERROR_PENDING !== 1'b1; k++) step(1);
        `CHK("err set", 1'b1, ERROR_PENDING)
        step(10);
        `CHK("err held", 1'b1, ERROR_PENDING)
        `CHK("ch stopped", 1'b0, CH_ENABLED[1])
        `CHK("no write", ctl, mem_i.mem[sa + CTL_OFS])
        err_on = 1'b0;
        CH_REQ = '0;
        ERR_CLEAR = 1'b1;
        step(1);
        ERR_CLEAR = 1'b0;
        step(1);
        `CHK("err clear", 1'b0, ERROR_PENDING)
        // A structure with nothing left must release its channel without a write-back or a done pulse.
        start(32'h8000_0400, 0, 1'b0, 10'h000);
        for (k = 0; k < 40; k++) begin
            step(1);
            `CHK("no done", 1'b0, CH_DONE[0])
        end
        `CHK("released", 1'b0, CH_ENABLED[0])
        `CHK("untouched", ctl, mem_i.mem[sa + CTL_OFS])
        RST = 1'b1;
        step(2);
        `CHK("reset base", 32'h0000_0000, BASE_PTR)
        `CHK("reset valid", 1'b0, BASE_VALID)
        RST = 1'b0;
        step(2);
        `CHK("reset idle", 1'b0, ACTIVE)
        `CHK("reset error", 1'b0, ERROR_PENDING)
        complete_run();
    end
endmodule // mdc_core_bench
`default_nettype wire
